// file: common/edma_consts.vh
// Constants for the eight-channel DMA controller: offsets, fields, sizes
`ifndef EDMA_CONSTS_VH
`define EDMA_CONSTS_VH

// ----------------------------------------------------------------------------
// Global register byte offsets
// ----------------------------------------------------------------------------
`define EDMA_OFF_STATUS     8'h00
`define EDMA_OFF_MASK       8'h04
`define EDMA_OFF_ACTIVE     8'h08
`define EDMA_OFF_HOSTCTL    8'h0C

// ----------------------------------------------------------------------------
// Channel registers: 0x80 + channel * 0x10 + index * 4
// ----------------------------------------------------------------------------
`define EDMA_CH_BASE_BIT    7
`define EDMA_CH_REG_CTRL    2'h0
`define EDMA_CH_REG_BASE    2'h1
`define EDMA_CH_REG_LEN     2'h2
`define EDMA_CH_REG_NBUF    2'h3

// ----------------------------------------------------------------------------
// Channel control fields
// ----------------------------------------------------------------------------
`define EDMA_CTL_EN         0
`define EDMA_CTL_TOMEM      1
`define EDMA_CTL_PSEL_LO    2
`define EDMA_CTL_PSEL_HI    3
`define EDMA_CTL_CONT       4
`define EDMA_CTL_IDX        5
`define EDMA_CTL_WIDE       6
`define EDMA_CTL_RESET      8'h00

// ----------------------------------------------------------------------------
// Peripheral codes and host control
// ----------------------------------------------------------------------------
`define EDMA_PER_XMEM       2'h0
`define EDMA_PER_SER0       2'h1
`define EDMA_PER_SER1       2'h2
`define EDMA_PER_HOST       2'h3
`define EDMA_HOST_PACK      0

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define EDMA_NCH            8
`define EDMA_NIDX           4
`define EDMA_FIFO_DEPTH     7'h40
`define EDMA_RX_ROOM        7'h3E

`endif

// file: rtl/edma_top.v
// Eight-channel DMA controller with Avalon-MM register slave and host FIFOs
// Summary of operation
// RULE1 - Eight channels: channels 0-3 indexed, channels 4-7 non-indexed.
// RULE2 - One end is internal RAM; other end is external memory, serial or host port.
// RULE3 - Next transfer programmed into shadow registers while current one runs.
// RULE4 - Indexed channels address memory sequentially or by time-slot index.
// RULE5 - Buffer length and buffer count programmed; pointer advances each transfer in frame.
// RULE6 - At frame end the memory address moves on and next frame starts.
// RULE7 - Words of 8 or 16 bits; frames of 1 to 128 slots.
// RULE8 - Non-indexed channels use sequential addresses only.
// RULE9 - One transfer per peripheral request, one request per word.
// RULE10 - After each non-indexed transfer the pointer moves to the next location.
// RULE11 - Pointer reaching buffer length raises an interrupt and ends that buffer.
// RULE12 - Final location of final buffer raises interrupt and sets channel status bit.
// RULE13 - Continuous mode restarts each completed transfer until software clears the bit.
// RULE14 - Host port bytes packed into 16-bit words and words split into bytes.
// RULE15 - Host transmit and receive directions each buffered by a 64-word FIFO.
// RULE16 - Simultaneous requests served one at a time, lowest channel first.
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "edma_consts.vh"

module edma_top (
    input  wire        CLK,
    input  wire        ARST_N,
    input  wire [7:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    input  wire [3:0]  AVS_BYTEENABLE,
    output reg  [31:0] AVS_READDATA,
    output reg         AVS_WAITREQUEST,
    output reg         IRQ,
    output reg  [15:0] MEM_ADDR,
    output reg         MEM_RE,
    output reg         MEM_WE,
    output reg  [15:0] MEM_WDATA,
    input  wire [15:0] MEM_RDATA,
    input  wire [3:0]  PER_REQ,
    input  wire [15:0] PER_RDATA,
    output reg  [1:0]  PER_SEL,
    output reg         PER_ACK,
    output reg         PER_WE,
    output reg  [15:0] PER_WDATA,
    input  wire        HOST_RX_VALID,
    input  wire [7:0]  HOST_RX_BYTE,
    output reg         HOST_RX_READY,
    output reg         HOST_TX_VALID,
    output reg  [7:0]  HOST_TX_BYTE,
    input  wire        HOST_TX_READY
);

    // ------------------------------------------------------------------------
    // Engine states
    // ------------------------------------------------------------------------
    localparam [3:0] S_IDLE  = 4'h1;
    localparam [3:0] S_WAIT  = 4'h2;
    localparam [3:0] S_READ  = 4'h4;
    localparam [3:0] S_WRITE = 4'h8;

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    function [2:0] first_set;
        input [7:0] v;
        integer i;
        begin
            first_set = 3'h0;
            for (i = 7; i >= 0; i = i - 1) begin
                if (v[i])
                    first_set = i[2:0];
            end
        end
    endfunction

    function [15:0] be16;
        input [15:0] old;
        input [31:0] wd;
        input [3:0]  be;
        begin
            be16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    function [15:0] wmask;
        input [15:0] d;
        input        wide;
        begin
            wmask = wide ? d : {8'h00, d[7:0]};
        end
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg  [7:0]  nctl_reg  [0:7];
    reg  [15:0] nbase_reg [0:7];
    reg  [15:0] nlen_reg  [0:7];
    reg  [6:0]  nnbuf_reg [0:7];
    reg  [7:0]  actl_reg  [0:7];
    reg  [15:0] abase_reg [0:7];
    reg  [15:0] alen_reg  [0:7];
    reg  [6:0]  anbuf_reg [0:7];
    reg  [15:0] addr_reg  [0:7];
    reg  [15:0] pos_reg   [0:7];
    reg  [6:0]  slot_reg  [0:7];
    reg  [6:0]  buf_reg   [0:7];
    reg  [7:0]  act_reg;
    reg  [7:0]  nv_reg;
    reg  [7:0]  pend_reg;
    reg  [15:0] stat_reg;
    reg  [15:0] mask_reg;
    reg         pack_reg;
    reg  [3:0]  st_reg;
    reg  [2:0]  cur_reg;
    reg  [15:0] data_reg;
    reg  [15:0] rx_mem [0:63];
    reg  [15:0] tx_mem [0:63];
    reg  [6:0]  rx_wp_reg;
    reg  [6:0]  rx_rp_reg;
    reg  [6:0]  tx_wp_reg;
    reg  [6:0]  tx_rp_reg;
    reg  [7:0]  rx_lo_reg;
    reg         rx_half_reg;
    reg  [7:0]  tx_hi_reg;
    reg         tx_half_reg;

    reg  [7:0]  elig;
    reg  [31:0] rd_mux;
    reg  [15:0] stat_next;
    reg  [7:0]  buf_ev;
    reg  [7:0]  fin_ev;
    reg         cur_idx;
    reg  [15:0] cur_pinc;
    reg         cur_lastpos;
    reg         cur_frame_end;
    integer     c;
    integer     k;

    wire [6:0]  rx_cnt  = rx_wp_reg - rx_rp_reg;
    wire [6:0]  tx_cnt  = tx_wp_reg - tx_rp_reg;
    wire        bus_req = AVS_READ | AVS_WRITE;
    wire        bus_wr  = AVS_WRITE & ~AVS_WAITREQUEST;
    wire        ch_hit  = AVS_ADDRESS[`EDMA_CH_BASE_BIT];
    wire [2:0]  ch_sel  = AVS_ADDRESS[6:4];
    wire [1:0]  ch_reg  = AVS_ADDRESS[3:2];
    wire [2:0]  grant   = first_set(elig);
    wire [7:0]  gctl    = actl_reg[grant];
    wire [7:0]  cctl    = actl_reg[cur_reg];
    wire        g_host  = gctl[`EDMA_CTL_PSEL_HI:`EDMA_CTL_PSEL_LO] == `EDMA_PER_HOST;
    wire        c_host  = cctl[`EDMA_CTL_PSEL_HI:`EDMA_CTL_PSEL_LO] == `EDMA_PER_HOST;
    wire        take    = (st_reg == S_IDLE) & (|elig);
    wire        adv     = (st_reg == S_WRITE);
    wire        rx_pop  = take & g_host & gctl[`EDMA_CTL_TOMEM];
    wire        tx_push = adv & c_host & ~cctl[`EDMA_CTL_TOMEM];
    wire        rx_push = HOST_RX_VALID & HOST_RX_READY & (~pack_reg | rx_half_reg);

    // ------------------------------------------------------------------------
    // Request eligibility and end-of-buffer detection
    // ------------------------------------------------------------------------
    always @* begin
        for (k = 0; k < `EDMA_NCH; k = k + 1) begin
            if (actl_reg[k][`EDMA_CTL_PSEL_HI:`EDMA_CTL_PSEL_LO] == `EDMA_PER_HOST) begin
                // Host channels are paced by FIFO level, not by a latched request
                if (actl_reg[k][`EDMA_CTL_TOMEM])
                    elig[k] = act_reg[k] & (rx_cnt != 7'h00);
                else
                    elig[k] = act_reg[k] & (tx_cnt != `EDMA_FIFO_DEPTH);
            end else begin
                elig[k] = act_reg[k] & pend_reg[k];  // see RULE9
            end
        end
        cur_idx       = (cur_reg < `EDMA_NIDX) & cctl[`EDMA_CTL_IDX];  // see RULE1, RULE8
        cur_pinc      = pos_reg[cur_reg] + 16'h0001;
        cur_lastpos   = cur_pinc == alen_reg[cur_reg];
        cur_frame_end = cur_idx ? (slot_reg[cur_reg] == anbuf_reg[cur_reg]) : 1'b1;
        buf_ev        = 8'h00;
        fin_ev        = 8'h00;
        if (adv && cur_frame_end && cur_lastpos) begin
            buf_ev[cur_reg] = 1'b1;  // see RULE11
            fin_ev[cur_reg] = cur_idx | (buf_reg[cur_reg] == anbuf_reg[cur_reg]);  // see RULE12
        end
    end

    // ------------------------------------------------------------------------
    // Channel registers, shadow programming and pointer update
    // ------------------------------------------------------------------------
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            act_reg  <= 8'h00;
            nv_reg   <= 8'h00;
            pend_reg <= 8'h00;
            for (c = 0; c < `EDMA_NCH; c = c + 1) begin
                nctl_reg[c]  <= `EDMA_CTL_RESET;
                nbase_reg[c] <= 16'h0000;
                nlen_reg[c]  <= 16'h0001;
                nnbuf_reg[c] <= 7'h00;
                actl_reg[c]  <= `EDMA_CTL_RESET;
                abase_reg[c] <= 16'h0000;
                alen_reg[c]  <= 16'h0001;
                anbuf_reg[c] <= 7'h00;
                addr_reg[c]  <= 16'h0000;
                pos_reg[c]   <= 16'h0000;
                slot_reg[c]  <= 7'h00;
                buf_reg[c]   <= 7'h00;
            end
        end else begin
            for (c = 0; c < `EDMA_NCH; c = c + 1) begin
                // A request in the grant cycle is kept: set wins over clear
                pend_reg[c] <= (pend_reg[c] & ~(take && grant == c))
                    | (act_reg[c] & PER_REQ[actl_reg[c][`EDMA_CTL_PSEL_HI:`EDMA_CTL_PSEL_LO]]);
                if (adv && cur_reg == c) begin
                    if (cur_idx) begin
                        if (cur_frame_end) begin
                            slot_reg[c] <= 7'h00;
                            pos_reg[c]  <= cur_pinc;
                            addr_reg[c] <= abase_reg[c] + cur_pinc;  // see RULE6
                        end else begin
                            slot_reg[c] <= slot_reg[c] + 7'h01;
                            addr_reg[c] <= addr_reg[c] + alen_reg[c];  // see RULE4, RULE5
                        end
                    end else begin
                        addr_reg[c] <= addr_reg[c] + 16'h0001;  // see RULE10
                        pos_reg[c]  <= cur_lastpos ? 16'h0000 : cur_pinc;
                        if (cur_lastpos)
                            buf_reg[c] <= buf_reg[c] + 7'h01;
                    end
                end
                if ((!act_reg[c] && nv_reg[c]) ||
                    (fin_ev[c] && (actl_reg[c][`EDMA_CTL_CONT] || nv_reg[c]))) begin
                    act_reg[c]  <= 1'b1;
                    pos_reg[c]  <= 16'h0000;
                    slot_reg[c] <= 7'h00;
                    buf_reg[c]  <= 7'h00;
                    if (nv_reg[c]) begin
                        // Shadow settings take over only at a boundary
                        nv_reg[c]    <= 1'b0;  // see RULE3
                        actl_reg[c]  <= nctl_reg[c];
                        abase_reg[c] <= nbase_reg[c];
                        alen_reg[c]  <= nlen_reg[c];
                        anbuf_reg[c] <= nnbuf_reg[c];
                        addr_reg[c]  <= nbase_reg[c];
                    end else begin
                        addr_reg[c] <= abase_reg[c];  // see RULE13
                    end
                end else if (fin_ev[c]) begin
                    act_reg[c] <= 1'b0;
                end
            end
            if (bus_wr && ch_hit) begin
                case (ch_reg)
                    `EDMA_CH_REG_CTRL: begin
                        if (AVS_BYTEENABLE[0]) begin
                            nctl_reg[ch_sel] <= {1'b0, AVS_WRITEDATA[6:0]};
                            nv_reg[ch_sel] <= AVS_WRITEDATA[`EDMA_CTL_EN];  // see RULE3
                            // Continuous bit acts on the running transfer too
                            actl_reg[ch_sel][`EDMA_CTL_CONT] <= AVS_WRITEDATA[`EDMA_CTL_CONT];  // see RULE13
                        end
                    end
                    `EDMA_CH_REG_BASE:
                        nbase_reg[ch_sel] <= be16(nbase_reg[ch_sel], AVS_WRITEDATA, AVS_BYTEENABLE);
                    `EDMA_CH_REG_LEN:
                        nlen_reg[ch_sel] <= be16(nlen_reg[ch_sel], AVS_WRITEDATA, AVS_BYTEENABLE);
                    default: begin
                        // Count minus one: 0..127 gives 1..128 buffers or slots
                        if (AVS_BYTEENABLE[0])
                            nnbuf_reg[ch_sel] <= AVS_WRITEDATA[6:0];  // see RULE7
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Transfer engine, one word at a time
    // ------------------------------------------------------------------------
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_reg    <= S_IDLE;
            cur_reg   <= 3'h0;
            data_reg  <= 16'h0000;
            MEM_ADDR  <= 16'h0000;
            MEM_RE    <= 1'b0;
            MEM_WE    <= 1'b0;
            MEM_WDATA <= 16'h0000;
            PER_SEL   <= 2'h0;
            PER_ACK   <= 1'b0;
            PER_WE    <= 1'b0;
            PER_WDATA <= 16'h0000;
        end else begin
            MEM_RE  <= 1'b0;
            MEM_WE  <= 1'b0;
            PER_ACK <= 1'b0;
            PER_WE  <= 1'b0;
            case (st_reg)
                S_IDLE: begin
                    if (take) begin
                        cur_reg <= grant;  // see RULE16
                        PER_SEL <= gctl[`EDMA_CTL_PSEL_HI:`EDMA_CTL_PSEL_LO];  // see RULE2
                        if (gctl[`EDMA_CTL_TOMEM]) begin
                            data_reg <= wmask(g_host ? rx_mem[rx_rp_reg[5:0]] : PER_RDATA,
                                              gctl[`EDMA_CTL_WIDE]);  // see RULE7
                            PER_ACK  <= ~g_host;
                            st_reg   <= S_WRITE;
                        end else begin
                            MEM_RE   <= 1'b1;
                            MEM_ADDR <= addr_reg[grant];
                            st_reg   <= S_WAIT;
                        end
                    end
                end
                S_WAIT:
                    st_reg <= S_READ;
                S_READ: begin
                    data_reg <= wmask(MEM_RDATA, cctl[`EDMA_CTL_WIDE]);
                    st_reg   <= S_WRITE;
                end
                S_WRITE: begin
                    if (cctl[`EDMA_CTL_TOMEM]) begin
                        MEM_WE    <= 1'b1;
                        MEM_ADDR  <= addr_reg[cur_reg];
                        MEM_WDATA <= data_reg;
                    end else if (!c_host) begin
                        PER_WE    <= 1'b1;
                        PER_WDATA <= data_reg;
                    end
                    st_reg <= S_IDLE;
                end
                default:
                    st_reg <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Host port FIFOs with byte packing and splitting
    // ------------------------------------------------------------------------
    always @(posedge CLK) begin
        if (rx_push)
            rx_mem[rx_wp_reg[5:0]] <= pack_reg ? {HOST_RX_BYTE, rx_lo_reg}
                                               : {8'h00, HOST_RX_BYTE};  // see RULE14
        if (tx_push)
            tx_mem[tx_wp_reg[5:0]] <= data_reg;  // see RULE15
    end

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_wp_reg     <= 7'h00;
            rx_rp_reg     <= 7'h00;
            tx_wp_reg     <= 7'h00;
            tx_rp_reg     <= 7'h00;
            rx_lo_reg     <= 8'h00;
            rx_half_reg   <= 1'b0;
            tx_hi_reg     <= 8'h00;
            tx_half_reg   <= 1'b0;
            HOST_RX_READY <= 1'b0;
            HOST_TX_VALID <= 1'b0;
            HOST_TX_BYTE  <= 8'h00;
        end else begin
            // Two words of margin cover the one-cycle lag of the ready flop
            HOST_RX_READY <= rx_cnt < `EDMA_RX_ROOM;  // see RULE15
            if (HOST_RX_VALID && HOST_RX_READY && pack_reg) begin
                rx_half_reg <= ~rx_half_reg;
                rx_lo_reg   <= HOST_RX_BYTE;  // see RULE14
            end
            if (rx_push)
                rx_wp_reg <= rx_wp_reg + 7'h01;
            if (rx_pop)
                rx_rp_reg <= rx_rp_reg + 7'h01;
            if (tx_push)
                tx_wp_reg <= tx_wp_reg + 7'h01;
            if (!HOST_TX_VALID || HOST_TX_READY) begin
                if (tx_half_reg) begin
                    HOST_TX_VALID <= 1'b1;
                    HOST_TX_BYTE  <= tx_hi_reg;
                    tx_half_reg   <= 1'b0;
                end else if (tx_cnt != 7'h00) begin
                    HOST_TX_VALID <= 1'b1;
                    HOST_TX_BYTE  <= tx_mem[tx_rp_reg[5:0]][7:0];
                    tx_hi_reg     <= tx_mem[tx_rp_reg[5:0]][15:8];
                    tx_half_reg   <= pack_reg;  // see RULE14
                    tx_rp_reg     <= tx_rp_reg + 7'h01;
                end else begin
                    HOST_TX_VALID <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register slave, interrupt status and mask
    // ------------------------------------------------------------------------
    always @* begin
        rd_mux = 32'h00000000;
        if (ch_hit) begin
            case (ch_reg)
                `EDMA_CH_REG_CTRL:
                    rd_mux = {pos_reg[ch_sel], 7'h00, act_reg[ch_sel], nv_reg[ch_sel],
                              nctl_reg[ch_sel][6:0]};
                `EDMA_CH_REG_BASE: rd_mux = {16'h0000, nbase_reg[ch_sel]};
                `EDMA_CH_REG_LEN:  rd_mux = {16'h0000, nlen_reg[ch_sel]};
                default:           rd_mux = {addr_reg[ch_sel], 9'h000, nnbuf_reg[ch_sel]};
            endcase
        end else begin
            case (AVS_ADDRESS)
                `EDMA_OFF_STATUS:  rd_mux = {16'h0000, stat_reg};
                `EDMA_OFF_MASK:    rd_mux = {16'h0000, mask_reg};
                `EDMA_OFF_ACTIVE:  rd_mux = {16'h0000, nv_reg, act_reg};
                `EDMA_OFF_HOSTCTL: rd_mux = {1'b0, tx_cnt, 1'b0, rx_cnt, 15'h0000, pack_reg};
                default:           rd_mux = 32'h00000000;
            endcase
        end
        // A completion in the clearing cycle stays set
        stat_next = stat_reg | {buf_ev, fin_ev};  // see RULE11, RULE12
        if (bus_wr && !ch_hit && AVS_ADDRESS == `EDMA_OFF_STATUS)
            stat_next = (stat_reg & ~be16(16'h0000, AVS_WRITEDATA, AVS_BYTEENABLE))
                        | {buf_ev, fin_ev};
    end

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h00000000;
            stat_reg        <= 16'h0000;
            mask_reg        <= 16'h0000;
            pack_reg        <= 1'b0;
            IRQ             <= 1'b0;
        end else begin
            // One wait cycle: answer at the second edge of each request
            AVS_WAITREQUEST <= ~(bus_req & AVS_WAITREQUEST);
            if (bus_req && AVS_WAITREQUEST)
                AVS_READDATA <= rd_mux;
            stat_reg <= stat_next;
            IRQ      <= |(stat_next & mask_reg);
            if (bus_wr && !ch_hit && AVS_ADDRESS == `EDMA_OFF_MASK)
                mask_reg <= be16(mask_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
            if (bus_wr && !ch_hit && AVS_ADDRESS == `EDMA_OFF_HOSTCTL && AVS_BYTEENABLE[0])
                pack_reg <= AVS_WRITEDATA[`EDMA_HOST_PACK];
        end
    end

endmodule // edma_top
`default_nettype wire

// file: testbench/edma_far.sv
// Far-side model: sync internal RAM and a counting peripheral data source
`timescale 1ns/1ps
`default_nettype none
module edma_far (
    input  wire logic        clk,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_re,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_wdata,
    output logic      [15:0] mem_rdata,
    input  wire logic        per_ack,
    output logic      [15:0] per_rdata
);
    logic [15:0] mem [0:255];
    logic [7:0]  n_reg = 8'h00;
    // Read data only valid the cycle after a read; scrambled otherwise
    always @(posedge clk) begin
        if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
        mem_rdata <= mem_re ? mem[mem_addr[7:0]] : ~mem_rdata;
        if (per_ack) n_reg <= n_reg + 8'h01;
    end
    assign per_rdata = {8'hA5, n_reg};
endmodule // edma_far
`default_nettype wire

// file: testbench/edma_top_asserts.sv
// Port-level checker for the eight-channel DMA controller
`timescale 1ns/1ps
`default_nettype none
module edma_chk (
    input wire logic       CLK,
    input wire logic       ARST_N,
    input wire logic       AVS_READ,
    input wire logic       AVS_WRITE,
    input wire logic       AVS_WAITREQUEST,
    input wire logic       MEM_RE,
    input wire logic       MEM_WE,
    input wire logic [1:0] PER_SEL,
    input wire logic       PER_ACK,
    input wire logic       PER_WE,
    input wire logic       IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus request not answered next cycle");
    a_wait_one: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    a_ack_then_we: assert property (PER_ACK |=> MEM_WE)
        else $error("taken word not written to memory");
    a_read_to_per: assert property (MEM_RE && PER_SEL != 2'h3 |-> ##3 PER_WE)
        else $error("memory read not delivered to peripheral");
    a_per_we_cause: assert property (PER_WE |-> $past(MEM_RE, 3))
        else $error("peripheral write without memory read");
    a_we_pulse: assert property (MEM_WE |=> !MEM_WE)
        else $error("memory write strobe too long");
    a_one_at_time: assert property (PER_ACK |=> !PER_ACK)
        else $error("two grants back to back");
    a_no_rw_clash: assert property (!(MEM_RE && MEM_WE))
        else $error("memory read and write together");
    c_ack: cover property (PER_ACK);
    c_per_we: cover property (PER_WE);
    c_irq: cover property ($rose(IRQ));
endmodule // edma_chk
bind edma_top edma_chk edma_chk_inst (.*);
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the eight-channel DMA controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        CLK = 1'b0, ARST_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic        AVS_WAITREQUEST, IRQ, MEM_RE, MEM_WE, PER_ACK, PER_WE, HOST_RX_READY;
    logic        HOST_RX_VALID = 1'b0, HOST_TX_READY = 1'b1, HOST_TX_VALID;
    logic [7:0]  AVS_ADDRESS = 8'h00, HOST_RX_BYTE = 8'h00, HOST_TX_BYTE;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q, pw;
    logic [3:0]  AVS_BYTEENABLE = 4'hF, PER_REQ = 4'h0;
    logic [15:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, PER_RDATA, PER_WDATA;
    logic [1:0]  PER_SEL;
    int          fail_count = 0, n_compared = 0, cyc = 0;
    edma_top edma_top_inst (.*);
    edma_far far_inst (.clk(CLK), .mem_addr(MEM_ADDR), .mem_re(MEM_RE), .mem_we(MEM_WE),
        .mem_wdata(MEM_WDATA), .mem_rdata(MEM_RDATA), .per_ack(PER_ACK), .per_rdata(PER_RDATA));
    initial forever #50 CLK = ~CLK;
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Generous ceiling: the whole sequence needs under two hundred cycles
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= ~wr;
        @(posedge CLK);
        while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK);
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic prog(input logic [7:0] ch, input logic [15:0] b, l, nb, input logic [7:0] c);
        bus(1'b1, ch + 8'h04, {16'h0, b});
        bus(1'b1, ch + 8'h08, {16'h0, l});
        bus(1'b1, ch + 8'h0C, {16'h0, nb});
        bus(1'b1, ch, {24'h0, c});
    endtask
    // One request pulse, then wait for the peripheral acknowledge or the peripheral write strobe
    task automatic req(input int p);
        PER_REQ[p] <= 1'b1;
        @(posedge CLK);
        PER_REQ <= 4'h0;
        while (PER_ACK !== 1'b1 && PER_WE !== 1'b1) @(posedge CLK);
        pw = {16'h0, PER_WDATA};
        repeat (3) @(posedge CLK);
    endtask
    task automatic t_regs();
        bus(1'b0, 8'h00, 32'h0);
        chk("status", q, 32'h0);
        bus(1'b1, 8'h40, 32'hFFFF);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", q, 32'h0);
    endtask
    task automatic t_seq();
        prog(8'hC0, 16'h0010, 16'h0003, 16'h0000, 8'h47);
        repeat (3) req(1);
        for (int i = 0; i < 3; i++) chk("seq", {16'h0, far_inst.mem[16 + i]}, 32'hA500 + i);
        bus(1'b0, 8'h00, 32'h0);
        chk("status", q, 32'h1010);
        bus(1'b1, 8'h04, 32'h10);
        repeat (2) @(posedge CLK);
        chk("irq", IRQ, 32'h1);
        bus(1'b1, 8'h00, 32'h1010);
        repeat (2) @(posedge CLK);
        chk("irq", IRQ, 32'h0);
    endtask
    task automatic t_idx();
        prog(8'h80, 16'h0020, 16'h0002, 16'h0001, 8'h67);
        repeat (4) req(1);
        for (int i = 0; i < 4; i++)
            chk("idx", {16'h0, far_inst.mem[32 + 2 * (i % 2) + i / 2]}, 32'hA503 + i);
        bus(1'b0, 8'h00, 32'h0);
        chk("status", q, 32'h0101);
    endtask
    task automatic t_rd();
        prog(8'hD0, 16'h0010, 16'h0001, 16'h0000, 8'h49);
        req(2);
        chk("per wdata", pw, 32'hA500);
    endtask
    task automatic t_host();
        bus(1'b1, 8'h0C, 32'h1);
        prog(8'hE0, 16'h0011, 16'h0001, 16'h0000, 8'h5D);
        for (int i = 0; i < 3; i++) begin
            @(posedge CLK);
            while (HOST_TX_VALID !== 1'b1) @(posedge CLK);
            chk("tx byte", HOST_TX_BYTE, i == 1 ? 32'hA5 : 32'h01);
        end
        bus(1'b1, 8'hE0, 32'h0);
        repeat (4) @(posedge CLK);
        bus(1'b0, 8'h08, 32'h0);
        chk("active", q, 32'h0);
    endtask
    initial begin
        repeat (3) @(posedge CLK);
        ARST_N <= 1'b1;
        @(posedge CLK);
        t_regs();
        t_seq();
        t_idx();
        t_rd();
        t_host();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
